/* shared/oet_regs.vh */
`ifndef OET_REGS_VH
`define OET_REGS_VH
// wishbone word offsets (byte addresses)
`define OET_ADDR_CTRL      8'h00
`define OET_ADDR_CMD       8'h04
`define OET_ADDR_STATUS    8'h08
`define OET_ADDR_IRQ_STAT  8'h0c
`define OET_ADDR_IRQ_EN    8'h10
`define OET_ADDR_IRQ_CLR   8'h14
`define OET_ADDR_PULSE     8'h18
// ctrl fields
`define OET_CTRL_INVERT    0
`define OET_CTRL_IGNORE    1
`define OET_CTRL_STANDBY   2
`define OET_CTRL_RESET     32'h0000_0000
// cmd fields (write 1 to act)
`define OET_CMD_ON         0
`define OET_CMD_OFF        1
`define OET_CMD_TRIG_SETUP 2
`define OET_CMD_LIST_CLEAR 3
// status fields
`define OET_ST_OUTPUT_ON   0
`define OET_ST_SHUTDOWN    1
`define OET_ST_STANDBY     2
`define OET_ST_TRIG_MODE   3
`define OET_ST_TRIG_ARMED  4
`define OET_ST_PULSE_BUSY  5
// event bits
`define OET_EV_TRIGGER     0
`define OET_EV_SHUTDOWN    1
`define OET_EV_STANDBY     2
`define OET_EV_OUT_CHANGE  3
`define OET_EV_WIDTH       4
// pulse register: bit 16 = active level, bits 15:0 = width in cycles
`define OET_PULSE_LEVEL    16
`define OET_PULSE_RESET    32'h0000_0064
// timing, microseconds and clock rate in MHz
`define OET_CLK_MHZ        100
`define OET_QUAL_US        100
`define OET_ONOFF_MAX_US   200000
`define OET_TRIG_MAX_US    500
`define OET_SD_MAX_US      100
`define OET_QUAL_CYC       (`OET_QUAL_US * `OET_CLK_MHZ)
`define OET_ONOFF_CYC      (`OET_ONOFF_MAX_US * `OET_CLK_MHZ)
`endif

/* verilog/oet_io_ctrl.v */
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "oet_regs.vh"
module oet_io_ctrl #(
  parameter QUAL_CYC = `OET_QUAL_CYC
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  output wire        wb_err_o,
  input  wire        remote_on_off_i,
  input  wire        external_trigger_input_i,
  input  wire        shutdown_led_i,
  output reg         output_enable_o,
  output reg         fault_indicator_red_o,
  output reg         power_good_flag_o,
  output reg         output_off_flag_o,
  output reg         trigger_event_o,
  output wire        irq_o
);
  localparam CW = 24;

  // three-stage synchronisers; the level changes only when the last two stages agree
  reg [2:0] onoff_sync_ff;
  reg [2:0] trig_sync_ff;
  reg [2:0] sd_sync_ff;
  reg       onoff_lvl_ff;
  reg       trig_lvl_ff;
  reg       sd_lvl_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      onoff_sync_ff <= 3'h7;
      trig_sync_ff  <= 3'h7;
      sd_sync_ff    <= 3'h0;
      onoff_lvl_ff  <= 1'b1;
      trig_lvl_ff   <= 1'b1;
      sd_lvl_ff     <= 1'b0;
    end else begin
      onoff_sync_ff <= {onoff_sync_ff[1:0], remote_on_off_i};
      trig_sync_ff  <= {trig_sync_ff[1:0], external_trigger_input_i};
      sd_sync_ff    <= {sd_sync_ff[1:0], shutdown_led_i};
      if (onoff_sync_ff[1] == onoff_sync_ff[2])
        onoff_lvl_ff <= onoff_sync_ff[2];
      if (trig_sync_ff[1] == trig_sync_ff[2])
        trig_lvl_ff <= trig_sync_ff[2];
      if (sd_sync_ff[1] == sd_sync_ff[2])
        sd_lvl_ff <= sd_sync_ff[2];
    end
  end

  // wishbone slave, single-cycle ack
  reg  [31:0] ctrl_ff;
  reg  [31:0] pulse_cfg_ff;
  reg  [3:0]  irq_en_ff;
  reg  [3:0]  irq_stat_ff;
  reg         ack_ff;
  wire        wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire        wb_wr  = wb_req & wb_we_i;

  function hit;
    input [7:0] adr;
    input [7:0] want;
    begin
      hit = (adr == want);
    end
  endfunction

  wire mapped = hit(wb_adr_i, `OET_ADDR_CTRL) |
                hit(wb_adr_i, `OET_ADDR_CMD) |
                hit(wb_adr_i, `OET_ADDR_STATUS) |
                hit(wb_adr_i, `OET_ADDR_IRQ_STAT) |
                hit(wb_adr_i, `OET_ADDR_IRQ_EN) |
                hit(wb_adr_i, `OET_ADDR_IRQ_CLR) |
                hit(wb_adr_i, `OET_ADDR_PULSE);
  reg err_ff;
  assign wb_ack_o = ack_ff;
  assign wb_err_o = err_ff;

  wire wr_cmd = wb_wr & hit(wb_adr_i, `OET_ADDR_CMD) & wb_sel_i[0];
  wire cmd_output_on          = wr_cmd & wb_dat_i[`OET_CMD_ON];
  wire cmd_output_off         = wr_cmd & wb_dat_i[`OET_CMD_OFF];
  wire cmd_list_trigger_setup = wr_cmd & wb_dat_i[`OET_CMD_TRIG_SETUP];
  wire cmd_list_clear         = wr_cmd & wb_dat_i[`OET_CMD_LIST_CLEAR];

  wire ctl_invert  = ctrl_ff[`OET_CTRL_INVERT];
  wire ctl_ignore  = ctrl_ff[`OET_CTRL_IGNORE];
  wire ctl_standby = ctrl_ff[`OET_CTRL_STANDBY];

  // low qualification counters
  reg  [CW-1:0] onoff_cnt_ff;
  reg  [CW-1:0] trig_cnt_ff;
  reg           trig_armed_ff;
  reg           sd_latch_ff;
  reg           standby_ff;
  reg           out_on_ff;
  reg           trig_mode_ff;
  reg  [15:0]   pulse_cnt_ff;
  reg           pulse_lvl_ff;
  // width is captured with the level, so later writes wait for a new setup
  reg  [15:0]   pulse_wid_ff;

  wire onoff_asserted_low = ctl_invert ? onoff_lvl_ff : ~onoff_lvl_ff;
  wire onoff_low_q  = (onoff_cnt_ff >= QUAL_CYC[CW-1:0]);
  wire trig_low_q   = (trig_cnt_ff >= QUAL_CYC[CW-1:0]);
  wire trig_fire    = trig_low_q & trig_armed_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      onoff_cnt_ff <= {CW{1'b0}};
      trig_cnt_ff  <= {CW{1'b0}};
    end else begin
      // glitches shorter than the window restart the count
      if (onoff_asserted_low & ~onoff_low_q)
        onoff_cnt_ff <= onoff_cnt_ff + 1'b1;
      else if (~onoff_asserted_low)
        onoff_cnt_ff <= {CW{1'b0}};
      if (~trig_lvl_ff & ~trig_low_q)
        trig_cnt_ff <= trig_cnt_ff + 1'b1;
      else if (trig_lvl_ff)
        trig_cnt_ff <= {CW{1'b0}};
    end
  end

  // trigger: one event per low, re-armed by high
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_armed_ff   <= 1'b1;
      trigger_event_o <= 1'b0;
    end else begin
      trigger_event_o <= trig_fire;
      if (trig_fire)
        trig_armed_ff <= 1'b0;
      else if (trig_lvl_ff)
        trig_armed_ff <= 1'b1;
    end
  end

  // output state; shutdown latch clears only on reset (power cycle)
  reg nxt_out_on;
  reg nxt_standby;
  always @* begin
    nxt_out_on  = out_on_ff;
    nxt_standby = standby_ff;
    if (ctl_ignore) begin
      if (cmd_output_on)
        nxt_out_on = 1'b1;
      if (cmd_output_off)
        nxt_out_on = 1'b0;
    end else if (ctl_standby) begin
      if (onoff_low_q) begin
        nxt_out_on  = 1'b0;
        nxt_standby = 1'b1;
      end else if (cmd_output_on) begin
        nxt_out_on  = 1'b1;
        nxt_standby = 1'b0;
      end else if (cmd_output_off) begin
        nxt_out_on = 1'b0;
      end
    end else begin
      // plain level mode: input follows within one qualify window
      nxt_standby = 1'b0;
      nxt_out_on  = ~onoff_low_q;
    end
    if (sd_latch_ff | sd_lvl_ff)
      nxt_out_on = 1'b0;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      sd_latch_ff <= 1'b0;
      out_on_ff   <= 1'b0;
      standby_ff  <= 1'b0;
    end else begin
      if (sd_lvl_ff)
        sd_latch_ff <= 1'b1;
      out_on_ff  <= nxt_out_on;
      standby_ff <= nxt_standby;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      output_enable_o       <= 1'b0;
      fault_indicator_red_o <= 1'b0;
      power_good_flag_o     <= 1'b0;
    end else begin
      output_enable_o       <= nxt_out_on;
      fault_indicator_red_o <= sd_latch_ff | sd_lvl_ff;
      power_good_flag_o     <= ~(sd_latch_ff | sd_lvl_ff);
    end
  end

  // output-off flag: state mirror or programmed trigger pulse
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_mode_ff      <= 1'b0;
      pulse_cnt_ff      <= 16'h0000;
      pulse_lvl_ff      <= 1'b0;
      pulse_wid_ff      <= 16'h0000;
      output_off_flag_o <= 1'b1;
    end else begin
      if (cmd_list_clear)
        trig_mode_ff <= 1'b0;
      else if (cmd_list_trigger_setup) begin
        trig_mode_ff <= 1'b1;
        pulse_lvl_ff <= pulse_cfg_ff[`OET_PULSE_LEVEL];
        pulse_wid_ff <= pulse_cfg_ff[15:0];
      end
      if (trig_mode_ff & trig_fire)
        pulse_cnt_ff <= pulse_wid_ff;
      else if (pulse_cnt_ff != 16'h0000)
        pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
      if (trig_mode_ff)
        output_off_flag_o <= (pulse_cnt_ff != 16'h0000) ? pulse_lvl_ff
                                                        : ~pulse_lvl_ff;
      else
        output_off_flag_o <= ~nxt_out_on;
    end
  end

  // sticky events, set wins over clear
  wire [3:0] ev;
  assign ev[`OET_EV_TRIGGER]    = trig_fire;
  assign ev[`OET_EV_SHUTDOWN]   = sd_lvl_ff & ~sd_latch_ff;
  assign ev[`OET_EV_STANDBY]    = nxt_standby & ~standby_ff;
  assign ev[`OET_EV_OUT_CHANGE] = nxt_out_on ^ out_on_ff;
  wire wr_clr = wb_wr & hit(wb_adr_i, `OET_ADDR_IRQ_CLR) & wb_sel_i[0];

  genvar gi;
  generate
    for (gi = 0; gi < `OET_EV_WIDTH; gi = gi + 1) begin : g_irq
      always @(posedge clk_i) begin
        if (rst_i)
          irq_stat_ff[gi] <= 1'b0;
        else if (ev[gi])
          irq_stat_ff[gi] <= 1'b1;
        else if (wr_clr & wb_dat_i[gi])
          irq_stat_ff[gi] <= 1'b0;
      end
    end
  endgenerate
  assign irq_o = |(irq_stat_ff & irq_en_ff);

  // register writes and reads
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff      <= `OET_CTRL_RESET;
      pulse_cfg_ff <= `OET_PULSE_RESET;
      irq_en_ff    <= 4'h0;
      ack_ff       <= 1'b0;
      err_ff       <= 1'b0;
      wb_dat_o     <= 32'h0000_0000;
    end else begin
      ack_ff <= wb_req & mapped;
      err_ff <= wb_req & ~mapped;
      if (wb_wr & hit(wb_adr_i, `OET_ADDR_CTRL) & wb_sel_i[0])
        ctrl_ff[2:0] <= wb_dat_i[2:0];
      if (wb_wr & hit(wb_adr_i, `OET_ADDR_IRQ_EN) & wb_sel_i[0])
        irq_en_ff <= wb_dat_i[3:0];
      if (wb_wr & hit(wb_adr_i, `OET_ADDR_PULSE)) begin
        if (wb_sel_i[0]) pulse_cfg_ff[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) pulse_cfg_ff[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) pulse_cfg_ff[16]    <= wb_dat_i[16];
      end
      wb_dat_o <= 32'h0000_0000;
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `OET_ADDR_CTRL:     wb_dat_o <= {29'h0, ctrl_ff[2:0]};
          `OET_ADDR_STATUS:   wb_dat_o <= {26'h0, (pulse_cnt_ff != 16'h0000),
                                          trig_armed_ff, trig_mode_ff,
                                          standby_ff, sd_latch_ff, out_on_ff};
          `OET_ADDR_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat_ff};
          `OET_ADDR_IRQ_EN:   wb_dat_o <= {28'h0, irq_en_ff};
          `OET_ADDR_PULSE:    wb_dat_o <= {15'h0, pulse_cfg_ff[16:0]};
          default:            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // oet_io_ctrl

/* test/oet_io_ctrl_checker.sv */
`timescale 1ns/1ps
module oet_io_ctrl_checker #(
  parameter int QUAL_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic external_trigger_input_i,
  input wire logic shutdown_led_i,
  input wire logic output_enable_o,
  input wire logic fault_indicator_red_o,
  input wire logic power_good_flag_o,
  input wire logic trigger_event_o
);
  logic [15:0] low_ff;
  logic        rearm_ff;
  // raw pin low run, and whether the pin went high since the last event
  always_ff @(posedge clk_i) begin
    if (rst_i || external_trigger_input_i) begin
      low_ff   <= 16'h0000;
      rearm_ff <= 1'b1;
    end else begin
      if (low_ff != 16'hffff)
        low_ff <= low_ff + 16'h0001;
      if (trigger_event_o)
        rearm_ff <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_fault_held;
    fault_indicator_red_o ##1 fault_indicator_red_o;
  endsequence
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_err_excl_a: assert property (!(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  sd_quick_off_a: assert property (
    shutdown_led_i |-> ##[0:10] (fault_indicator_red_o && !output_enable_o))
    else $error("shutdown not acted on in time");
  sd_latch_a: assert property (
    fault_indicator_red_o |=> fault_indicator_red_o)
    else $error("shutdown latch cleared without reset");
  sd_no_output_a: assert property (
    s_fault_held |=> !output_enable_o)
    else $error("output on while shut down");
  pg_released_a: assert property (
    s_fault_held |=> !power_good_flag_o)
    else $error("power good held while shut down");
  trig_single_a: assert property (
    trigger_event_o |=> !trigger_event_o)
    else $error("trigger event longer than one cycle");
  trig_qualified_a: assert property (
    trigger_event_o |-> low_ff >= QUAL_CYC)
    else $error("trigger on a short low");
  trig_rearm_a: assert property (
    trigger_event_o |-> rearm_ff)
    else $error("trigger without re-arm");
endmodule // oet_io_ctrl_checker

/* test/oet_ext_ctrl.sv */
`timescale 1ns/1ps
module oet_ext_ctrl (
  input  wire logic clk_i,
  output logic      on_off_o,
  output logic      trig_o,
  output logic      sd_o
);
  initial begin
    on_off_o = 1'b1;
    trig_o   = 1'b1;
    sd_o     = 1'b0;
  end
  // pin 0 on/off, 1 trigger, 2 shutdown; bench holds a trigger low past
  // the qualify time and high again before the next one
  task automatic pin(input int p, input logic v);
    @(posedge clk_i);
    if (p == 0)
      on_off_o <= v;
    else if (p == 1)
      trig_o <= v;
    else
      sd_o <= v;
  endtask
  task automatic low(input int p, input int n);
    pin(p, 1'b0);
    repeat (n) @(posedge clk_i);
    pin(p, 1'b1);
  endtask
endmodule // oet_ext_ctrl

/* test/oet_io_ctrl_tb.sv */
`timescale 1ns/1ps
`include "oet_regs.vh"
module oet_io_ctrl_tb;
  localparam int Q = 8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        ack, err, oe, red, pg, off, tev, irq, on_off, trig, sd;
  int          miscompares = 0;
  int          checks_done = 0;
  int          tev_n, off_n;
  wire  [5:0]  outs = {pg, tev, irq, off, red, oe};
  oet_io_ctrl #(.QUAL_CYC(Q)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .remote_on_off_i(on_off),
    .external_trigger_input_i(trig), .shutdown_led_i(sd),
    .output_enable_o(oe), .fault_indicator_red_o(red),
    .power_good_flag_o(pg), .output_off_flag_o(off),
    .trigger_event_o(tev), .irq_o(irq));
  oet_ext_ctrl u_ext (.clk_i(clk_i), .on_off_o(on_off), .trig_o(trig),
    .sd_o(sd));
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic e);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1 && ++n < 20);
    q = rdat;
    chk("err", e, err);
    chk("ack", !e, ack);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wt(input string nm, input int i, input logic v, int n);
    int k;
    k = 0;
    while (outs[i] !== v && k++ < n) @(posedge clk_i);
    chk(nm, v, outs[i]);
  endtask
  // counts trigger events and active (low) pulse cycles over n edges
  task automatic cnt(input int n);
    tev_n = 0;
    off_n = 0;
    repeat (n) begin
      @(posedge clk_i);
      tev_n += tev;
      off_n += !off;
    end
  endtask
  task automatic reset;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_regs;
    bus(0, `OET_ADDR_PULSE, 0, 0);
    chk("pulse", `OET_PULSE_RESET, q);
    bus(0, `OET_ADDR_CTRL, 0, 0);
    chk("ctrl", `OET_CTRL_RESET, q);
    bus(0, 8'h40, 0, 1);
  endtask
  task automatic t_plain;
    wt("oe_hi", 0, 1, 20);
    chk("off_lo", 0, off);
    u_ext.low(0, Q / 2);
    repeat (Q + 8) @(posedge clk_i);
    chk("glitch", 1, oe);
    u_ext.pin(0, 0);
    wt("oe_lo", 0, 0, Q + 10);
    chk("off_hi", 1, off);
    u_ext.pin(0, 1);
    bus(1, `OET_ADDR_CTRL, 32'h1, 0);
    wt("inv_off", 0, 0, Q + 10);
    u_ext.pin(0, 0);
    wt("inv_on", 0, 1, Q + 10);
    u_ext.pin(0, 1);
  endtask
  task automatic t_ignore;
    bus(1, `OET_ADDR_CTRL, 32'h2, 0);
    bus(1, `OET_ADDR_CMD, 32'h1, 0);
    wt("ign_on", 0, 1, 10);
    u_ext.low(0, Q + 10);
    chk("ign_hold", 1, oe);
    bus(1, `OET_ADDR_CMD, 32'h2, 0);
    wt("ign_off", 0, 0, 10);
  endtask
  task automatic t_standby;
    bus(1, `OET_ADDR_CTRL, 32'h4, 0);
    bus(1, `OET_ADDR_IRQ_CLR, 32'hf, 0);
    bus(1, `OET_ADDR_IRQ_EN, 32'h4, 0);
    bus(1, `OET_ADDR_CMD, 32'h1, 0);
    wt("sb_on", 0, 1, 10);
    chk("irq_lo", 0, irq);
    u_ext.low(0, Q + 10);
    chk("sb_off", 0, oe);
    repeat (10) @(posedge clk_i);
    chk("sb_stay", 0, oe);
    chk("irq_hi", 1, irq);
    bus(0, `OET_ADDR_STATUS, 0, 0);
    chk("sb_st", 32'h4, q & 32'h5);
    bus(1, `OET_ADDR_IRQ_EN, 0, 0);
    chk("irq_mask", 0, irq);
    bus(1, `OET_ADDR_IRQ_CLR, 32'hf, 0);
    bus(1, `OET_ADDR_IRQ_EN, 32'h4, 0);
    chk("irq_clr", 0, irq);
    bus(1, `OET_ADDR_CMD, 32'h1, 0);
    wt("sb_cmd_on", 0, 1, 10);
  endtask
  task automatic t_trig;
    bus(1, `OET_ADDR_CTRL, 0, 0);
    bus(1, `OET_ADDR_PULSE, 32'h4, 0);
    bus(1, `OET_ADDR_CMD, 32'h4, 0);
    bus(1, `OET_ADDR_PULSE, 32'h2, 0);
    chk("idle", 1, off);
    for (int t = 0; t < 2; t++) begin
      u_ext.pin(1, 0);
      cnt(3 * Q);
      chk("tev", 1, tev_n);
      chk("width", 4, off_n);
      u_ext.pin(1, 1);
      repeat (6) @(posedge clk_i);
    end
    bus(1, `OET_ADDR_CMD, 32'h8, 0);
    chk("revert", !oe, off);
  endtask
  task automatic t_shutdown;
    bus(1, `OET_ADDR_CTRL, 32'h2, 0);
    chk("pg_ok", 1, pg);
    u_ext.pin(2, 1);
    wt("sd_red", 1, 1, 10);
    repeat (2) @(posedge clk_i);
    chk("sd_oe", 0, oe);
    u_ext.pin(2, 0);
    repeat (10) @(posedge clk_i);
    bus(1, `OET_ADDR_CMD, 32'h1, 0);
    chk("sd_latch", 0, oe);
    chk("pg_off", 0, pg);
    reset;
    wt("pg_back", 5, 1, 5);
  endtask
  task automatic end_sim;
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    reset;
    t_regs;
    t_plain;
    t_ignore;
    t_standby;
    t_trig;
    t_shutdown;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    end_sim;
  end
endmodule // oet_io_ctrl_tb
bind oet_io_ctrl oet_io_ctrl_checker #(.QUAL_CYC(QUAL_CYC)) u_chk (.*);
